// >>> logic/gxp_pkg.sv
// Package for the eight-pin serial I/O expander core.
// Assumes a single 250 MHz system clock; all users refer to names as gxp_pkg::name.
package gxp_pkg;

  // ----------------------------------------------------------------------
  // Sizes, addresses and register offsets
  // ----------------------------------------------------------------------
  localparam int unsigned NPINS     = 8;         // Port width in pins.
  localparam logic [6:0]  ADDR_BASE = 7'h20;     // Slave address, select pin low.
  localparam logic [6:0]  ADDR_ALT  = 7'h21;     // Slave address, select pin high.
  localparam logic [1:0]  REG_INPUT = 2'h0;      // Command: input register.
  localparam logic [1:0]  REG_OUT   = 2'h1;      // Command: output register.
  localparam logic [1:0]  REG_POL   = 2'h2;      // Command: polarity inversion.
  localparam logic [1:0]  REG_CFG   = 2'h3;      // Command: direction (1 = input).

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_OUT   = 8'hff;     // Output register default.
  localparam logic [7:0]  RST_POL   = 8'h00;     // No inversion after reset.
  localparam logic [7:0]  RST_CFG   = 8'hff;     // Every pin an input after reset.

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 250;   // System clock rate.
  localparam int unsigned ALERT_VALID_NS  = 4000;  // Longest alert valid delay.
  localparam int unsigned ALERT_VALID_CYC = (ALERT_VALID_NS * CLK_MHZ) / 1000;

  // Serial engine states.
  typedef enum logic [2:0] {
    GXP_IDLE, GXP_ADDR, GXP_ACK, GXP_WRB, GXP_RDB, GXP_RACK
  } gxp_state_t;

  // Synchronised serial and pin inputs.
  typedef struct packed {
    logic [1:0] scl;
    logic [1:0] sda;
    logic [1:0] sel;
    logic [NPINS-1:0] pa;
    logic [NPINS-1:0] pb;
  } gxp_sync_t;

  // Serial engine and register state of the core.
  typedef struct packed {
    gxp_state_t state;
    logic [3:0] bitc;        // Bit counter inside a byte.
    logic [7:0] shf;         // Shift register.
    logic       rw;          // Direction of the current frame.
    logic       first;       // Next written byte is the command byte.
    logic [1:0] cmd;         // Register pointer.
    logic       sda_lo;      // Drive serial data low.
    logic       scl_p;       // Previous serial clock level.
    logic       sda_p;       // Previous serial data level.
    logic       rd_in;       // Current read byte came from the input register.
    logic [7:0] inreg;       // Input register.
    logic [7:0] outreg;      // Output register.
    logic [7:0] pol;         // Polarity inversion register.
    logic [7:0] cfg;         // Direction register.
  } gxp_st_t;

endpackage : gxp_pkg

// >>> logic/gxp_core.sv
// Eight-pin I/O expander core: serial slave, four registers, change alert.
// Assumes serial lines, pins and the select strap come from outside the clock domain.
`timescale 1ns/100ps

module gxp_core (
  input  wire logic                     clk_i,        // System clock, 250 MHz.
  input  wire logic                     resetn_i,     // Asynchronous reset, active low.
  input  wire logic                     scl_i,        // Serial clock from the master.
  input  wire logic                     sda_i,        // Serial data line level.
  output logic                          sda_o,        // Serial data drive value, always low.
  output logic                          sda_oe_o,     // High while pulling serial data low.
  input  wire logic                     addr_sel_i,   // Slave address select strap.
  input  wire logic [gxp_pkg::NPINS-1:0] port_pins_i, // Port pin levels.
  output logic [gxp_pkg::NPINS-1:0]     port_pins_o,  // Port pin drive values.
  output logic [gxp_pkg::NPINS-1:0]     port_pins_oe_o, // Port pin drive enables.
  output logic                          alert_n_o,    // Alert drive value, always low.
  output logic                          alert_n_oe_o  // High while pulling alert low.
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // Every outside level passes two flops; only the second stage is read.
  gxp_pkg::gxp_sync_t sy_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sy_q <= '{scl: 2'h3, sda: 2'h3, sel: 2'h0, pa: 8'h00, pb: 8'h00};
    end else begin
      sy_q.scl <= {sy_q.scl[0], scl_i};
      sy_q.sda <= {sy_q.sda[0], sda_i};
      sy_q.sel <= {sy_q.sel[0], addr_sel_i};
      sy_q.pa  <= port_pins_i;
      sy_q.pb  <= sy_q.pa;
    end
  end

  gxp_pkg::gxp_st_t st_q; // Registered state.
  gxp_pkg::gxp_st_t st_d; // Next state.

  logic       scl_s;   // Synchronised serial clock.
  logic       sda_s;   // Synchronised serial data.
  logic [7:0] pins_s;  // Synchronised pin levels.
  logic [7:0] view;    // Pin levels after polarity inversion.
  logic [6:0] my_addr; // Active slave address.
  assign scl_s   = sy_q.scl[1];
  assign sda_s   = sy_q.sda[1];
  assign pins_s  = sy_q.pb;
  assign view    = pins_s ^ st_q.pol;
  assign my_addr = sy_q.sel[1] ? gxp_pkg::ADDR_ALT : gxp_pkg::ADDR_BASE;

  // ----------------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------------
  logic scl_rise, scl_fall, start_c, stop_c;

  // Edge and bus condition detection on synchronised lines.
  always_comb begin
    scl_rise = scl_s & ~st_q.scl_p;
    scl_fall = ~scl_s & st_q.scl_p;
    start_c  = scl_s & st_q.scl_p & st_q.sda_p & ~sda_s;
    stop_c   = scl_s & st_q.scl_p & ~st_q.sda_p & sda_s;
  end

  // Register read multiplexer.
  function automatic logic [7:0] rd_mux(input logic [1:0] c, input gxp_pkg::gxp_st_t s);
    unique case (c)
      gxp_pkg::REG_INPUT: rd_mux = s.inreg;
      gxp_pkg::REG_OUT:   rd_mux = s.outreg;
      gxp_pkg::REG_POL:   rd_mux = s.pol;
      gxp_pkg::REG_CFG:   rd_mux = s.cfg;
    endcase
  endfunction

  // Next-state logic: serial slave plus input capture.
  // A port read sends the live pin levels and the input register takes them
  // at that byte's acknowledge, so an input pin that moves raises the alert until
  // the next port read or until it returns.
  always_comb begin
    st_d       = st_q;
    st_d.scl_p = scl_s;
    st_d.sda_p = sda_s;
    if (start_c) begin
      st_d.state  = gxp_pkg::GXP_ADDR;
      st_d.bitc   = 4'h0;
      st_d.sda_lo = 1'b0;
      st_d.first  = 1'b1;
      st_d.rd_in  = 1'b0;
    end else if (stop_c) begin
      st_d.state  = gxp_pkg::GXP_IDLE;  // Frames for other slaves end here too.
      st_d.sda_lo = 1'b0;
      st_d.rd_in  = 1'b0;
    end else begin
      unique case (st_q.state)
        gxp_pkg::GXP_IDLE: st_d.sda_lo = 1'b0;
        gxp_pkg::GXP_ADDR, gxp_pkg::GXP_WRB: begin
          if (scl_rise) begin
            st_d.shf  = {st_q.shf[6:0], sda_s};
            st_d.bitc = st_q.bitc + 4'h1;
          end
          if (scl_fall && st_q.bitc == 4'h8) begin
            st_d.bitc = 4'h0;
            if (st_q.state == gxp_pkg::GXP_ADDR) begin
              if (st_q.shf[7:1] == my_addr) begin
                st_d.rw     = st_q.shf[0];
                st_d.sda_lo = 1'b1;
                st_d.state  = gxp_pkg::GXP_ACK;
              end else begin
                st_d.state  = gxp_pkg::GXP_IDLE; // Not ours: ignore until next start.
              end
            end else begin
              st_d.sda_lo = 1'b1;
              st_d.state  = gxp_pkg::GXP_ACK;
              if (st_q.first) begin
                st_d.cmd   = st_q.shf[1:0];
                st_d.first = 1'b0;
              end else begin
                unique case (st_q.cmd)
                  gxp_pkg::REG_INPUT: ;                    // Input register is read-only.
                  gxp_pkg::REG_OUT:   st_d.outreg = st_q.shf;
                  gxp_pkg::REG_POL:   st_d.pol    = st_q.shf;
                  gxp_pkg::REG_CFG:   st_d.cfg    = st_q.shf;
                endcase
              end
            end
          end
        end
        gxp_pkg::GXP_ACK: begin
          if (scl_fall) begin
            if (st_q.rw) begin
              // A port read sends the present levels, not the last snapshot.
              st_d.shf    = (st_q.cmd == gxp_pkg::REG_INPUT) ? view : rd_mux(st_q.cmd, st_q);
              st_d.rd_in  = (st_q.cmd == gxp_pkg::REG_INPUT);
              st_d.sda_lo = ~st_d.shf[7];
              st_d.bitc   = 4'h0;
              st_d.state  = gxp_pkg::GXP_RDB;
            end else begin
              st_d.sda_lo = 1'b0;
              st_d.state  = gxp_pkg::GXP_WRB;
            end
          end
        end
        gxp_pkg::GXP_RDB: begin
          if (scl_fall) begin
            st_d.bitc = st_q.bitc + 4'h1;
            if (st_q.bitc == 4'h7) begin
              st_d.sda_lo = 1'b0;
              st_d.state  = gxp_pkg::GXP_RACK;
            end else begin
              st_d.shf    = {st_q.shf[6:0], 1'b0};
              st_d.sda_lo = ~st_q.shf[6];
            end
          end
        end
        gxp_pkg::GXP_RACK: begin
          // Acknowledge clock rise: a port read clears the alert here.
          if (scl_rise) begin
            if (st_q.rd_in) begin
              st_d.inreg = view;
            end
            st_d.rd_in = 1'b0;
            st_d.state = sda_s ? gxp_pkg::GXP_IDLE : gxp_pkg::GXP_ACK;
          end
        end
        default: st_d.state = gxp_pkg::GXP_IDLE;
      endcase
    end
  end

  // State register with defaults under reset.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= '{state: gxp_pkg::GXP_IDLE, bitc: 4'h0, shf: 8'h00, rw: 1'b0, first: 1'b1,
                cmd: 2'h0, sda_lo: 1'b0, scl_p: 1'b1, sda_p: 1'b1, rd_in: 1'b0,
                inreg: 8'h00, outreg: gxp_pkg::RST_OUT, pol: gxp_pkg::RST_POL,
                cfg: gxp_pkg::RST_CFG};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pins, alert and serial data drive
  // ----------------------------------------------------------------------
  logic [7:0] diff; // Input pins differing from the input register.
  assign diff = (view ^ st_q.inreg) & st_q.cfg;

  // Alert drive is registered so the open-drain output never glitches.
  logic alert_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= |diff;
    end
  end

  assign alert_n_o      = 1'b0;
  assign alert_n_oe_o   = alert_q;
  assign sda_o          = 1'b0;
  assign sda_oe_o       = st_q.sda_lo;
  assign port_pins_o    = st_q.outreg;
  assign port_pins_oe_o = ~st_q.cfg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_ack_rise;
    st_q.state == gxp_pkg::GXP_RACK && scl_rise && st_q.rd_in;
  endsequence

  a_input_tristate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (port_pins_oe_o & st_q.cfg) == 8'h00) else $error("Input pin is driven.");
  a_output_value: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (port_pins_o == st_q.outreg) && (port_pins_oe_o == ~st_q.cfg)) else $error("Pin drive mismatch.");
  a_alert_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (|diff) |=> alert_n_oe_o) else $error("Alert missed a change.");
  a_alert_release: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (diff == 8'h00) |=> !alert_n_oe_o) else $error("Alert held without cause.");
  a_read_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_ack_rise |=> (st_q.inreg == $past(view))) else $error("Port read did not capture.");
  a_output_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st_q.cfg == 8'h00) |=> !alert_n_oe_o) else $error("Output pin raised alert.");
  a_addr_select: assert property (@(posedge clk_i) disable iff (!resetn_i)
    my_addr == (sy_q.sel[1] ? 7'h21 : 7'h20)) else $error("Wrong slave address.");
  a_inreg_frozen: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !(st_q.state == gxp_pkg::GXP_RACK && scl_rise) |=> $stable(st_q.inreg)) else $error("Input register moved.");

endmodule // gxp_core

// >>> testbench/gxp_i2c_master.sv
// Serial bus master model that drives the clock and data lines of the expander core.
// Assumes the bench resolves the data wire with a pull-up and runs clk_i at 250 MHz.
`timescale 1ns/100ps

module gxp_i2c_master (
  input  wire logic clk_i,      // Bench clock that paces the link.
  input  wire logic sda_i,      // Resolved data wire level.
  output logic      scl_o,      // Serial clock, stands high outside frames.
  output logic      sda_pull_o  // High while the master pulls data low.
);
  // ----------------------------------------------------------------------
  // Bus phases: 20 clocks per half period give a 160 ns link clock.
  // ----------------------------------------------------------------------
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  // Waits n rising edges, so every line change lands just after an edge.
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start_c();
    wt(5);
    sda_pull_o <= 1'b0;
    wt(15);
    scl_o <= 1'b1;
    wt(20);
    sda_pull_o <= 1'b1;
    wt(20);
    scl_o <= 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the bus stands idle.
  task automatic stop_c();
    wt(5);
    sda_pull_o <= 1'b1;
    wt(15);
    scl_o <= 1'b1;
    wt(20);
    sda_pull_o <= 1'b0;
    wt(20);
  endtask

  // Nine bits, MSB first; data moves only while the clock is low, a 1 releases the wire.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      wt(5);
      sda_pull_o <= ~tx[i];
      wt(15);
      scl_o <= 1'b1;
      wt(20);
      rx[i] = sda_i;
      scl_o <= 1'b0;
    end
  endtask

  // Addressed write, or command then repeated start and a one-byte read closed by a NACK.
  task automatic acc(input logic [6:0] a, input logic rd, input logic [1:0] c,
                     input logic [7:0] d, output logic [7:0] q, output logic ok);
    logic [8:0] r0, r1, r2, r3;
    r2 = 9'h000;
    start_c();
    xfer({a, 1'b0, 1'b1}, r0);
    xfer({6'h00, c, 1'b1}, r1);
    if (rd) begin
      start_c();
      xfer({a, 1'b1, 1'b1}, r2);
      xfer(9'h1ff, r3);
    end else begin
      xfer({d, 1'b1}, r3);
    end
    stop_c();
    q  = r3[8:1];
    ok = ~(r0[0] | r1[0] | r2[0] | (~rd & r3[0]));
  endtask
endmodule // gxp_i2c_master

// >>> testbench/tb_gxp_core.sv
// Self-checking bench for the expander core with a serial master model.
// Assumes open-drain data and alert wires with pull-ups, and pins shared with an outside driver.
`timescale 1ns/100ps

module tb_gxp_core;
  // ----------------------------------------------------------------------
  // Signals, wire resolution and reference state
  // ----------------------------------------------------------------------
  logic       clk_i, resetn_i, addr_sel_i, scl, sda_pull, ok, sda_o, sda_oe_o, alert_n_o, alert_n_oe_o;
  logic [6:0] dev;                                   // Address the master uses.
  logic [7:0] ext_q, sv, q, pins_o, pins_oe;         // Outside pin drive and observed values.
  logic [7:0] cfg_m, out_m, pol_m, in_m;             // Reference copies of the four registers.
  int         err_count, samples_checked, seed;
  wire        sda_w   = ~(sda_pull | (sda_oe_o & ~sda_o));
  wire        alert_w = ~(alert_n_oe_o & ~alert_n_o);
  wire  [7:0] pins_w  = (pins_oe & pins_o) | (~pins_oe & ext_q);

  gxp_i2c_master m (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(sda_pull));
  gxp_core dut (.clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
                .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i), .port_pins_i(pins_w),
                .port_pins_o(pins_o), .port_pins_oe_o(pins_oe), .alert_n_o(alert_n_o),
                .alert_n_oe_o(alert_n_oe_o));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Cuts a hang short; a clean run needs about four fifths of this span.
  initial begin
    #360000;
    err_count++;
    close_out();
  end

  // ----------------------------------------------------------------------
  // Expectations and checking tasks
  // ----------------------------------------------------------------------
  function automatic logic [7:0] pin_exp();
    return (~cfg_m & out_m) | (cfg_m & ext_q);
  endfunction

  // Only input pins take part, so output pins can never raise the alert.
  function automatic logic alert_exp();
    return |((pin_exp() ^ pol_m ^ in_m) & cfg_m);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic alchk();
    check({7'h0, alert_w}, {7'h0, ~alert_exp()});
  endtask

  task automatic wr(input logic [1:0] c, input logic [7:0] d);
    m.acc(dev, 1'b0, c, d, q, ok);
    check({7'h0, ok}, 8'h01);
    if (c == gxp_pkg::REG_OUT) out_m = d;
    else if (c == gxp_pkg::REG_POL) pol_m = d;
    else cfg_m = d;
  endtask

  // Reads one register; an input read also reloads the reference input register.
  task automatic rdchk(input logic [1:0] c);
    logic [7:0] e;
    e = (c == gxp_pkg::REG_INPUT) ? (pin_exp() ^ pol_m) : (c == gxp_pkg::REG_OUT) ? out_m :
        (c == gxp_pkg::REG_POL) ? pol_m : cfg_m;
    m.acc(dev, 1'b1, c, 8'h00, q, ok);
    check(q, e);
    check({7'h0, ok}, 8'h01);
    if (c == gxp_pkg::REG_INPUT) in_m = e;
    alchk();
  endtask

  // Reset held for eight clocks; outputs must already rest while it is low.
  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(pins_oe, 8'h00);
    resetn_i <= 1'b1;
    cfg_m = gxp_pkg::RST_CFG;
    out_m = gxp_pkg::RST_OUT;
    pol_m = gxp_pkg::RST_POL;
    in_m  = 8'h00;
    repeat (10) @(posedge clk_i);
    check(pins_oe, 8'h00);
    alchk();
    for (int k = 0; k < 4; k++) rdchk(2'(k));
  endtask

  task automatic close_out();
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence: random directions and data, corners at both ends
  // ----------------------------------------------------------------------
  initial begin
    seed = 87;
    err_count = 0;
    samples_checked = 0;
    resetn_i = 1'b0;
    addr_sel_i = 1'b0;
    ext_q = 8'h00;
    dev = gxp_pkg::ADDR_BASE;
    @(posedge clk_i);
    do_reset();
    for (int i = 0; i < 6; i++) begin
      addr_sel_i <= i[0];
      dev = i[0] ? gxp_pkg::ADDR_ALT : gxp_pkg::ADDR_BASE;
      wr(gxp_pkg::REG_CFG, (i == 0) ? 8'h00 : (i == 5) ? 8'hff : 8'($random(seed)));
      check(pins_oe, ~cfg_m);
      wr(gxp_pkg::REG_OUT, 8'($random(seed)));
      wr(gxp_pkg::REG_POL, 8'($random(seed)));
      check(pins_w & ~cfg_m, out_m & ~cfg_m);
      rdchk(gxp_pkg::REG_INPUT);
      rdchk(2'(i));
      wr(gxp_pkg::REG_OUT, 8'($random(seed)));
      alchk();
      sv = ext_q;
      ext_q <= ext_q ^ 8'($random(seed)) ^ 8'h01;
      repeat (10) @(posedge clk_i);
      alchk();
      m.acc(dev ^ 7'h01, 1'b1, gxp_pkg::REG_INPUT, 8'h00, q, ok);
      check({7'h0, ok}, 8'h00);
      alchk();
      ext_q <= sv;
      repeat (10) @(posedge clk_i);
      alchk();
    end
    do_reset();
    close_out();
  end
endmodule // tb_gxp_core
